/* File: core/sis_pkg.sv */
package sis_pkg;
   // register map
   localparam logic [11:0] SIS_ADDR_CTRL_STATUS = 12'h000;
   localparam logic [11:0] SIS_ADDR_RESET_CAUSE = 12'h004;
   localparam logic [11:0] SIS_ADDR_IRQ_INFO = 12'h008;
   // field positions
   localparam int SIS_BIT_IRQ_ENABLE = 6;
   localparam int SIS_BIT_WARN_FLAG = 5;
   localparam int SIS_BIT_BROWNOUT = 4;
   localparam int SIS_BIT_WATCHDOG = 0;
   // reset values
   localparam logic [7:0] SIS_CTRL_RESET = 8'h00;
   // interrupt vector
   localparam logic [7:0] SIS_IRQ_VECTOR = 8'h0b;
   localparam logic [15:0] SIS_IRQ_VEC_ADDR = 16'hffe4;
   // time in ns the reset pin is held low after a brownout ends, the clock period, and the hold in cycles
   localparam int SIS_PIN_HOLD_NS = 500;
   localparam int SIS_CLK_NS = 100;
   localparam logic [3:0] SIS_PIN_HOLD_CYC = 4'((SIS_PIN_HOLD_NS + SIS_CLK_NS - 1) / SIS_CLK_NS);

   typedef enum logic [1:0] {
      SIS_SRC_PIN,
      SIS_SRC_WATCHDOG,
      SIS_SRC_BROWNOUT
   } sis_src_t;

   // reset events seen by the block
   typedef struct packed {
      logic brownout;
      logic watchdog;
   } sis_rst_evt_t;

   // apb request
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } sis_apb_req_t;
endpackage

/* File: core/sis_sync.sv */
module sis_sync
   import sis_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level in and out
   input wire logic d,
   output logic q
);
   logic meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

/* File: core/sis_pin_hold.sv */
module sis_pin_hold
   import sis_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // brownout level
   input wire logic brownout_active,
   // reset pin drive
   output logic pin_oe
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;

   assign next_cnt = brownout_active ? SIS_PIN_HOLD_CYC : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         pin_oe <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pin_oe <= brownout_active || (next_cnt != 4'h0);
      end
   end
endmodule

/* File: core/sis_top.sv */
// Function
// - enable set: warning flag change requests interrupt
// - pending cleared on interrupt entry
// - warning flag read-only, 1 means below threshold
// - brownout flag meaningless when detector disabled
// - watchdog flag set by hardware, cleared writing zero
// - brownout reset also clears watchdog flag
// - reset source decoded from both flags
// - writable control bits reset to zero
// - vector 11, lowest priority, no halt wake
// - warning detector active only with brownout enabled
// - brownout holds reset pin low
//
// Implementation choices: the register offsets and the APB register port.
module sis_top
   import sis_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog and option inputs
   input wire logic supply_warn_cmp,
   input wire logic brownout_enable,
   input wire logic brownout_event,
   input wire logic watchdog_event,
   // interrupt controller
   input wire logic irq_ack,
   input wire logic cpu_halted,
   output logic irq_req,
   output logic irq_wake,
   output logic [7:0] irq_vector,
   // reset pin, open drain
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe
);
   ////////////////////////////////////////////////////////////
   logic irq_enable;
   logic brownout_flag;
   logic watchdog_flag;
   logic warn_sync;
   logic warn_prev;
   logic warn_flag;
   logic pending;
   logic pin_oe;
   sis_rst_evt_t evt;
   sis_apb_req_t req;

   assign evt = '{brownout: brownout_event, watchdog: watchdog_event};
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   sis_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(supply_warn_cmp),
      .q(warn_sync)
   );

   sis_pin_hold u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .brownout_active(evt.brownout),
      .pin_oe(pin_oe)
   );

   ////////////////////////////////////////////////////////////
   // decode
   wire setup = req.sel && !req.enable;
   // writes land at the access edge, when pready is sampled high
   wire access = req.sel && req.enable && pready;
   wire wr = access && req.write;
   wire hit_ctrl = req.addr == SIS_ADDR_CTRL_STATUS;
   wire hit_cause = req.addr == SIS_ADDR_RESET_CAUSE;
   wire hit_info = req.addr == SIS_ADDR_IRQ_INFO;
   wire mapped = hit_ctrl || hit_cause || hit_info;
   wire wr_ctrl = wr && hit_ctrl;
   wire warn_active = brownout_enable && warn_sync;
   wire toggle = brownout_enable && (warn_sync != warn_prev);
   wire ack = irq_ack && pending;
   wire [7:0] ctrl_val = {1'b0, irq_enable, warn_flag, brownout_flag, 3'b000, watchdog_flag};
   wire sis_src_t src = brownout_flag ? SIS_SRC_BROWNOUT : (watchdog_flag ? SIS_SRC_WATCHDOG : SIS_SRC_PIN);
   wire [31:0] rd_val = hit_ctrl ? {24'h0, ctrl_val} :
                        hit_cause ? {30'h0, src} :
                        hit_info ? {16'h0, SIS_IRQ_VEC_ADDR} : 32'h0;
   // brownout flag: event wins over software clear
   wire next_brownout = evt.brownout ? 1'b1 :
                        (wr_ctrl && !req.wdata[SIS_BIT_BROWNOUT]) ? 1'b0 : brownout_flag;
   wire next_watchdog = evt.brownout ? 1'b0 :
                        evt.watchdog ? 1'b1 :
                        (wr_ctrl && !req.wdata[SIS_BIT_WATCHDOG]) ? 1'b0 : watchdog_flag;
   wire next_pending = (irq_enable && toggle) ? 1'b1 : (ack ? 1'b0 : pending);

   ////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable <= SIS_CTRL_RESET[SIS_BIT_IRQ_ENABLE];
         brownout_flag <= SIS_CTRL_RESET[SIS_BIT_BROWNOUT];
         watchdog_flag <= SIS_CTRL_RESET[SIS_BIT_WATCHDOG];
         warn_prev <= 1'b0;
         warn_flag <= 1'b0;
         pending <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            irq_enable <= req.wdata[SIS_BIT_IRQ_ENABLE];
         end
         brownout_flag <= next_brownout;
         watchdog_flag <= next_watchdog;
         warn_prev <= warn_sync;
         warn_flag <= warn_active;
         pending <= next_pending;
      end
   end

   // apb answer and outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq_req <= 1'b0;
         irq_wake <= 1'b0;
         irq_vector <= 8'h00;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !req.write) ? rd_val : 32'h0;
         irq_req <= next_pending;
         irq_wake <= 1'b0;
         irq_vector <= SIS_IRQ_VECTOR;
         reset_pin_out <= 1'b0;
         reset_pin_oe <= pin_oe;
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   a_toggle_pend: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_enable && toggle) |=> pending) else $error("toggle did not set pending");
   a_ack_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (ack && !(irq_enable && toggle)) |=> !pending) else $error("ack did not clear pending");
   a_warn_follow: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (warn_flag == $past(warn_active))) else $error("warn flag stale");
   a_bo_set: assert property (@(posedge pclk) disable iff (!presetn)
      evt.brownout |=> brownout_flag) else $error("brownout flag not set");
   a_wd_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ctrl && !req.wdata[0] && !evt.watchdog && !evt.brownout) |=> !watchdog_flag)
      else $error("watchdog flag not cleared");
   a_bo_wd_clr: assert property (@(posedge pclk) disable iff (!presetn)
      evt.brownout |=> !watchdog_flag) else $error("brownout left watchdog flag");
   a_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_halted |-> !irq_wake) else $error("wake from halt");
   a_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
      evt.brownout |-> ##2 reset_pin_oe [*2]) else $error("reset pin not held");
   a_gate_det: assert property (@(posedge pclk) disable iff (!presetn)
      !brownout_enable |=> !warn_flag) else $error("warn flag with detector off");
   a_pready: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready) else $error("no answer");
endmodule

/* File: verification/tb_sis_top.sv */
module tb_sis_top import sis_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic supply_warn_cmp, brownout_enable, brownout_event, watchdog_event;
   logic irq_ack, cpu_halted, irq_req, irq_wake, reset_pin_out, reset_pin_oe, errv;
   logic [7:0] irq_vector;
   wire logic reset_pin_in = reset_pin_oe ? reset_pin_out : 1'b1;
   int error_cnt = 0;
   int compares = 0;
   sis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_warn_cmp(supply_warn_cmp), .brownout_enable(brownout_enable),
      .brownout_event(brownout_event), .watchdog_event(watchdog_event), .irq_ack(irq_ack),
      .cpu_halted(cpu_halted), .irq_req(irq_req), .irq_wake(irq_wake), .irq_vector(irq_vector),
      .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t no pready", $time);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(0, a, 32'h0);
      chk(rdv & m, exp);
      chk({31'h0, errv}, 32'h0);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      final_report;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {supply_warn_cmp, brownout_event, watchdog_event, irq_ack, cpu_halted} = '0;
      brownout_enable = 1;
      tick(3);
      presetn <= 1;
      tick(1);
      rd(SIS_ADDR_CTRL_STATUS, 32'h00, 32'hff);
      chk({24'h0, irq_vector}, 32'h0000000b);
      rd(SIS_ADDR_RESET_CAUSE, 32'h0, 32'hff);
      rd(SIS_ADDR_IRQ_INFO, 32'h0000ffe4, 32'hffff);
      apb(0, 12'h00c, 32'h0);
      chk({errv, rdv[30:0]}, 32'h80000000);
      apb(1, SIS_ADDR_CTRL_STATUS, 32'h60);
      rd(SIS_ADDR_CTRL_STATUS, 32'h40, 32'hff);
      supply_warn_cmp <= 1;
      cpu_halted <= 1;
      tick(6);
      rd(SIS_ADDR_CTRL_STATUS, 32'h60, 32'hff);
      chk({irq_req, irq_wake}, 32'h2);
      irq_ack <= 1;
      tick(1);
      irq_ack <= 0;
      tick(1);
      chk(irq_req, 0);
      supply_warn_cmp <= 0;
      tick(6);
      chk(irq_req, 1);
      irq_ack <= 1;
      tick(1);
      irq_ack <= 0;
      apb(1, SIS_ADDR_CTRL_STATUS, 32'h00);
      brownout_enable <= 0;
      supply_warn_cmp <= 1;
      tick(6);
      rd(SIS_ADDR_CTRL_STATUS, 32'h00, 32'hff);
      chk(irq_req, 0);
      brownout_enable <= 1;
      supply_warn_cmp <= 0;
      watchdog_event <= 1;
      tick(1);
      watchdog_event <= 0;
      tick(2);
      rd(SIS_ADDR_CTRL_STATUS, 32'h01, 32'h11);
      rd(SIS_ADDR_RESET_CAUSE, 32'h1, 32'hff);
      apb(1, SIS_ADDR_CTRL_STATUS, 32'h00);
      rd(SIS_ADDR_CTRL_STATUS, 32'h00, 32'h11);
      watchdog_event <= 1;
      tick(1);
      watchdog_event <= 0;
      brownout_event <= 1;
      tick(3);
      chk({reset_pin_oe, reset_pin_out, reset_pin_in}, 32'h4);
      brownout_event <= 0;
      tick(2);
      rd(SIS_ADDR_CTRL_STATUS, 32'h10, 32'h11);
      rd(SIS_ADDR_RESET_CAUSE, 32'h2, 32'hff);
      tick(8);
      chk(reset_pin_oe, 0);
      apb(1, SIS_ADDR_CTRL_STATUS, 32'h00);
      rd(SIS_ADDR_CTRL_STATUS, 32'h00, 32'h11);
      rd(SIS_ADDR_RESET_CAUSE, 32'h0, 32'hff);
      final_report;
   end
endmodule
